// file: tb_wdts_timeout.sv
// testbench for the watchdog time-out select block
// assumes a fake oscillator of four clk cycles per period
`timescale 1ns/1ps
module tb_wdts_timeout;
    logic        clk, wdCountTick, earlyWarn, finalTimeout, secondHalf, codeReserved;
    logic        nrst = 1'b0;
    logic        wdOsc128k = 1'b0;
    logic        wdClear = 1'b0;
    logic [1:0]  divSel = 2'h0;
    logic [3:0]  timeoutCode = 4'h0;
    logic [21:0] cycleCount;
    int          nMismatch = 0;
    int          checks = 0;
    int          cyc = 0;

    wdts_timeout dut (
        .clk          (clk),
        .nrst         (nrst),
        .wdOsc128k    (wdOsc128k),
        .divSel       (divSel),
        .timeoutCode  (timeoutCode),
        .wdClear      (wdClear),
        .wdCountTick  (wdCountTick),
        .earlyWarn    (earlyWarn),
        .finalTimeout (finalTimeout),
        .secondHalf   (secondHalf),
        .codeReserved (codeReserved),
        .cycleCount   (cycleCount)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always begin
        repeat (2) @(negedge clk);
        wdOsc128k <= ~wdOsc128k;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 70000) begin
            nMismatch++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("mismatches %0d checks %0d", nMismatch, checks);
        if (nMismatch == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            nMismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic restart(input logic [1:0] d, input logic [3:0] c);
        @(negedge clk);
        wdClear = 1'b1;
        divSel = d;
        timeoutCode = c;
        @(negedge clk);
        wdClear = 1'b0;
    endtask : restart

    // clk cycles between two count ticks
    task automatic spacing(input logic [1:0] d, input logic [31:0] exp);
        logic [31:0] n;
        restart(d, 4'h0);
        n = 0;
        while (wdCountTick !== 1'b1) @(negedge clk);
        do begin
            @(negedge clk);
            n++;
        end while (wdCountTick !== 1'b1);
        chk(n, exp);
    endtask : spacing

    task automatic ticksTo(output logic [31:0] n, input bit fin);
        n = 0;
        do begin
            @(negedge clk);
            if (wdCountTick === 1'b1) n++;
        end while ((fin ? finalTimeout : earlyWarn) !== 1'b1);
    endtask : ticksTo

    task automatic intervals;
        logic [31:0] n;
        restart(2'h0, 4'h0);
        ticksTo(n, 1'b0);
        chk(n, 32'h800);
        chk({10'h0, cycleCount}, 32'h7ff);
        chk({31'h0, secondHalf}, 32'h1);
        ticksTo(n, 1'b1);
        chk(n, 32'h800);
        chk({10'h0, cycleCount}, 32'h7ff);
        restart(2'h0, 4'h1);
        ticksTo(n, 1'b0);
        chk(n, 32'h1000);
    endtask : intervals

    // reserved code must stay silent past a whole code-0 interval
    task automatic reserved;
        logic [31:0] n;
        restart(2'h0, 4'ha);
        n = 0;
        repeat (9000) begin
            @(negedge clk);
            if (earlyWarn === 1'b1 || finalTimeout === 1'b1) n++;
        end
        chk(n, 32'h0);
        chk({31'h0, codeReserved}, 32'h1);
        chk({10'h0, cycleCount}, 32'h0);
    endtask : reserved

    task automatic clearMid;
        logic [31:0] n;
        restart(2'h0, 4'h0);
        repeat (4000) @(negedge clk);
        restart(2'h0, 4'h0);
        ticksTo(n, 1'b0);
        chk(n, 32'h800);
    endtask : clearMid

    initial begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        spacing(2'h2, 32'h14);
        spacing(2'h3, 32'h1c);
        spacing(2'h1, 32'hc);
        intervals();
        reserved();
        clearMid();
        give_verdict();
    end
endmodule : tb_wdts_timeout

// file: wdts_clk_div.sv
// divides synchronised oscillator edges into counting-clock ticks
// assumes oscEdge is a one-cycle pulse on clk per oscillator rising edge
`timescale 1ns/1ps
module wdts_clk_div (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          restart,
    input  wire logic                          oscEdge,
    input  wire logic [wdts_pkg::DIVSEL_W-1:0] divSel,
    output logic                               tick
);
    logic [wdts_pkg::DIVCNT_W-1:0] divCount_reg;
    logic [wdts_pkg::DIVCNT_W-1:0] divLast;

    assign divLast = wdts_pkg::divisorFor(divSel) - wdts_pkg::DIV_BY_1;

    // >= so a setting lowered mid-count cannot run the counter past its end
    always_ff @(posedge clk) begin
        if (!nrst || restart) begin
            divCount_reg <= wdts_pkg::DIVCNT_RESET;
        end else if (oscEdge) begin
            if (divCount_reg >= divLast) begin
                divCount_reg <= wdts_pkg::DIVCNT_RESET;
            end else begin
                divCount_reg <= divCount_reg + wdts_pkg::DIV_BY_1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || restart) begin
            tick <= 1'b0;
        end else begin
            tick <= oscEdge && (divCount_reg >= divLast);
        end
    end

endmodule : wdts_clk_div

// file: wdts_pkg.sv
// constants, types and helpers for the watchdog time-out select block
// assumes a single system clock domain; the oscillator arrives as a pin level
package wdts_pkg;

    localparam int unsigned CODE_W      = 4;
    localparam int unsigned DIVSEL_W    = 2;
    localparam int unsigned DIVCNT_W    = 3;
    localparam int unsigned BASE_SHIFT  = 11;
    localparam int unsigned CNT_W       = 22;

    localparam logic [CODE_W-1:0]    CODE_LAST   = 4'h9;
    localparam logic [DIVSEL_W-1:0]  DIVSEL_DIV5 = 2'h2;
    localparam logic [DIVSEL_W-1:0]  DIVSEL_DIV7 = 2'h3;
    localparam logic [DIVSEL_W-1:0]  DIVSEL_DIV3 = 2'h1;

    localparam logic [DIVCNT_W-1:0]  DIV_BY_1    = 3'h1;
    localparam logic [DIVCNT_W-1:0]  DIV_BY_3    = 3'h3;
    localparam logic [DIVCNT_W-1:0]  DIV_BY_5    = 3'h5;
    localparam logic [DIVCNT_W-1:0]  DIV_BY_7    = 3'h7;

    localparam logic [DIVCNT_W-1:0]  DIVCNT_RESET = 3'h0;
    localparam logic [CNT_W-1:0]     CNT_RESET    = 22'h000000;
    localparam logic [CNT_W-1:0]     CNT_ONE      = 22'h000001;

    localparam int unsigned OSC_HZ      = 128000;
    localparam int unsigned CLK_HZ      = 25000000;

    typedef enum logic [1:0] {
        WDTS_FIRST  = 2'b01,
        WDTS_SECOND = 2'b10
    } wdts_state_t;

    // oscillator cycles per counting-clock cycle for a divider setting
    function automatic logic [DIVCNT_W-1:0] divisorFor(input logic [DIVSEL_W-1:0] sel);
        logic [DIVCNT_W-1:0] d;
        d = DIV_BY_1;
        case (sel)
            DIVSEL_DIV3: d = DIV_BY_3;
            DIVSEL_DIV5: d = DIV_BY_5;
            DIVSEL_DIV7: d = DIV_BY_7;
            default:     d = DIV_BY_1;
        endcase
        return d;
    endfunction : divisorFor

    // counting-clock cycles in one interval: 2048 doubled per code step
    function automatic logic [CNT_W-1:0] intervalFor(input logic [CODE_W-1:0] code);
        logic [CNT_W-1:0] n;
        n = CNT_ONE << (BASE_SHIFT + 32'(code));
        return n;
    endfunction : intervalFor

    function automatic logic codeIsReserved(input logic [CODE_W-1:0] code);
        return code > CODE_LAST;
    endfunction : codeIsReserved

endpackage : wdts_pkg

// file: wdts_timeout.sv
// watchdog time-out select: counting clock, early warning and final time-out
// assumes wdOsc128k is an asynchronous pin level far slower than clk;
// timeoutCode, divSel and wdClear come from logic on clk
`timescale 1ns/1ps
module wdts_timeout (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          wdOsc128k,
    input  wire logic [wdts_pkg::DIVSEL_W-1:0] divSel,
    input  wire logic [wdts_pkg::CODE_W-1:0]   timeoutCode,
    input  wire logic                          wdClear,
    output logic                               wdCountTick,
    output logic                               earlyWarn,
    output logic                               finalTimeout,
    output logic                               secondHalf,
    output logic                               codeReserved,
    output logic [wdts_pkg::CNT_W-1:0]         cycleCount
);
    logic                        oscMeta_reg;
    logic                        oscSync_reg;
    logic                        oscLast_reg;
    logic                        oscEdge;
    logic                        tick;
    logic [wdts_pkg::CNT_W-1:0]  count_reg;
    logic [wdts_pkg::CNT_W-1:0]  intervalLast;
    logic                        expire;
    logic                        reserved;
    wdts_pkg::wdts_state_t       state_reg;
    wdts_pkg::wdts_state_t       state_next;

    // two-flop synchroniser; only the second stage feeds the edge detector
    // reset high so a pin already high at release is not taken as a rising edge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            oscMeta_reg <= 1'b1;
            oscSync_reg <= 1'b1;
            oscLast_reg <= 1'b1;
        end else begin
            oscMeta_reg <= wdOsc128k;
            oscSync_reg <= oscMeta_reg;
            oscLast_reg <= oscSync_reg;
        end
    end

    assign oscEdge = oscSync_reg && !oscLast_reg;

    wdts_clk_div u_div (
        .clk     (clk),
        .nrst    (nrst),
        .restart (wdClear),
        .oscEdge (oscEdge),
        .divSel  (divSel),
        .tick    (tick)
    );

    // reserved codes stall counting rather than guess a length
    assign reserved     = wdts_pkg::codeIsReserved(timeoutCode);
    assign intervalLast = wdts_pkg::intervalFor(timeoutCode) - wdts_pkg::CNT_ONE;
    assign expire       = tick && !reserved && (count_reg >= intervalLast);

    always_ff @(posedge clk) begin
        if (!nrst || wdClear) begin
            count_reg <= wdts_pkg::CNT_RESET;
        end else if (expire) begin
            count_reg <= wdts_pkg::CNT_RESET;
        end else if (tick && !reserved) begin
            count_reg <= count_reg + wdts_pkg::CNT_ONE;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            wdts_pkg::WDTS_FIRST: begin
                if (expire) begin
                    state_next = wdts_pkg::WDTS_SECOND;
                end
            end
            wdts_pkg::WDTS_SECOND: begin
                if (expire) begin
                    state_next = wdts_pkg::WDTS_FIRST;
                end
            end
            default: state_next = wdts_pkg::WDTS_FIRST;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst || wdClear) begin
            state_reg <= wdts_pkg::WDTS_FIRST;
        end else begin
            state_reg <= state_next;
        end
    end

    // pulses are registered so they line up with the count they report
    always_ff @(posedge clk) begin
        if (!nrst || wdClear) begin
            earlyWarn    <= 1'b0;
            finalTimeout <= 1'b0;
        end else begin
            earlyWarn    <= expire && (state_reg == wdts_pkg::WDTS_FIRST);
            finalTimeout <= expire && (state_reg == wdts_pkg::WDTS_SECOND);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wdCountTick  <= 1'b0;
            secondHalf   <= 1'b0;
            codeReserved <= 1'b0;
            cycleCount   <= wdts_pkg::CNT_RESET;
        end else begin
            wdCountTick  <= tick;
            secondHalf   <= (state_next == wdts_pkg::WDTS_SECOND) && !wdClear;
            codeReserved <= reserved;
            cycleCount   <= count_reg;
        end
    end

endmodule : wdts_timeout

// file: wdts_timeout_chk.sv
// checker for the watchdog time-out select block
// assumes the bind below onto wdts_timeout
`timescale 1ns/1ps
module wdts_timeout_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wdOsc128k,
    input wire logic wdClear,
    input wire logic wdCountTick,
    input wire logic earlyWarn,
    input wire logic finalTimeout,
    input wire logic secondHalf,
    input wire logic codeReserved
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // a tick traces back through sync, edge, divider and output flops to a pin rise
    chk_tick_osc_edge: assert property (wdCountTick |-> $past(wdOsc128k, 4) && !$past(wdOsc128k, 5))
        else $error("count tick without oscillator edge");
    chk_early_on_tick: assert property (earlyWarn |-> wdCountTick && secondHalf)
        else $error("early warning off a tick");
    chk_final_ends_half: assert property (finalTimeout |-> wdCountTick && !secondHalf && $past(secondHalf))
        else $error("final time-out outside second interval");
    chk_half_from_early: assert property ($rose(secondHalf) |-> earlyWarn)
        else $error("second interval began without early warning");
    chk_final_not_soon: assert property (earlyWarn |=> !finalTimeout [*8])
        else $error("final time-out too soon after early warning");
    chk_clear_quiet: assert property (wdClear |=> !earlyWarn && !finalTimeout && !secondHalf)
        else $error("time-out while cleared");
    chk_reserved_silent: assert property (codeReserved |-> !earlyWarn && !finalTimeout)
        else $error("time-out with reserved code");
    cover property (earlyWarn);
    cover property (finalTimeout);
    cover property (codeReserved && wdCountTick);
endmodule : wdts_timeout_chk

bind wdts_timeout wdts_timeout_chk chk (
    .clk          (clk),
    .nrst         (nrst),
    .wdOsc128k    (wdOsc128k),
    .wdClear      (wdClear),
    .wdCountTick  (wdCountTick),
    .earlyWarn    (earlyWarn),
    .finalTimeout (finalTimeout),
    .secondHalf   (secondHalf),
    .codeReserved (codeReserved)
);
